/* File: hdl/dts_sequencer.sv */
// acquisition trigger sequencer with wishbone registers and dac update
//
// Behaviour
// - counter 0 paces, counter 1 counts samples
// - external convert falling edge starts conversion
// - trigger role chosen by mode bits
// - posttrigger gates interval counter until trigger rise
// - convert enabled from first rise after trigger
// - later trigger edges ignored until new setup
// - controlled mode stops conversions at count end
// - count loads late, two extra conversions
// - trigger also starts free-running acquisition
// - pretrigger converts early, sample counter gated
// - pretrigger stops after exactly programmed count
// - no mode bit means trigger ignored
// - low update level transfers selected dac values
// - dac write during low update is immediate
// - update rising edge always sets irq flag
// - enabled irq flag raises interrupt request
// - any write to clear register clears flag
// - aux counter rising output sets same flag
//
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
module dts_sequencer
    import dts_pkg::*;
#(
    parameter int unsigned CW = CNT_W,
    parameter int unsigned DW = DAC_W
)
(
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic          ce,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    input  wire logic          ext_convert_n,
    input  wire logic          ext_acq_trigger,
    input  wire logic          ext_dac_update_n,
    output logic               adc_convert,
    output logic      [DW-1:0] dac0_out,
    output logic      [DW-1:0] dac1_out,
    output logic               count_irq
);

    // whole state of the block in one word
    typedef struct packed {
        dts_ctrl_t     ctrl;
        logic [CW-1:0] interval;
        logic [CW-1:0] count_prog;
        logic [CW-1:0] aux_reload;
        logic [DW-1:0] dac0_data;
        logic [DW-1:0] dac1_data;
        logic [DW-1:0] dac0_q;
        logic [DW-1:0] dac1_q;
        logic [CW-1:0] interval_cnt;
        logic [CW-1:0] sample_cnt;
        logic [CW-1:0] aux_cnt;
        logic          aux_out;
        dts_sc_state_t sc;
        logic          trig_seen;
        logic          conv_armed;
        logic          count_irq_flag;
        logic          convert;
        logic          irq;
        logic          ack;
        logic [31:0]   rdata;
    } dts_state_t;

    dts_state_t r;
    dts_state_t s;
    dts_wb_req_t req;

    logic conv_rise, conv_fall;
    logic trig_rise;
    logic upd_level, upd_rise;

    // pin inputs, each through two flops before edge logic
    dts_edge_sync #(.RST_VAL(1'b1)) u_sync_conv (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .din    (ext_convert_n),
        .level  (),
        .rise   (conv_rise),
        .fall   (conv_fall)
    );

    dts_edge_sync #(.RST_VAL(1'b0)) u_sync_trig (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .din    (ext_acq_trigger),
        .level  (),
        .rise   (trig_rise),
        .fall   ()
    );

    dts_edge_sync #(.RST_VAL(1'b1)) u_sync_upd (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .din    (ext_dac_update_n),
        .level  (upd_level),
        .rise   (upd_rise),
        .fall   ()
    );

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

    // merge write data into an old word by byte lane
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                res[i*8 +: 8] = dat[i*8 +: 8];
        end
        return res;
    endfunction : lane_merge

    dts_trig_mode_t mode;
    logic           trig_take;
    logic           gate_on;
    logic           tick;
    logic           sc_enable;
    logic           wr_go;
    logic           setup_go;
    logic           irq_clr;
    logic           aux_rise;
    logic [31:0]    wmerged;
    dts_stat_t      stat;
    logic [CW-1:0]  ival_m1;

    always_comb
    begin
        s         = r;
        s.convert = 1'b0;
        s.ack     = 1'b0;
        tick      = 1'b0;
        aux_rise  = 1'b0;
        wmerged   = 32'h0000_0000;

        // pretrigger wins if software sets both; neither means pin unused
        if (r.ctrl.select_a)
            mode = TRIG_PRE;
        else if (r.ctrl.posttrig_select)
            mode = TRIG_POST;
        else
            mode = TRIG_NONE;

        // first trigger edge only, latched until the next setup
        trig_take = trig_rise && (mode != TRIG_NONE) && !r.trig_seen;
        if (trig_take)
            s.trig_seen = 1'b1;

        // conversion gate; posttrigger waits for the trigger
        gate_on = r.ctrl.acq_enable && (r.sc != SC_DONE)
                  && ((mode != TRIG_POST) || r.trig_seen);

        // external convert is armed by its first rise after the trigger
        if (mode == TRIG_POST && r.trig_seen && conv_rise)
            s.conv_armed = 1'b1;

        // interval counter 0, zero interval treated as one cycle
        ival_m1 = (r.interval == '0) ? '0 : r.interval - CW'(1);
        if (r.ctrl.ext_conv_enable)
        begin
            tick = conv_fall && ((mode != TRIG_POST) || r.conv_armed);
            s.interval_cnt = ival_m1;
        end
        else if (gate_on)
        begin
            if (r.interval_cnt == '0)
            begin
                tick           = 1'b1;
                s.interval_cnt = ival_m1;
            end
            else
                s.interval_cnt = r.interval_cnt - CW'(1);
        end
        else
            s.interval_cnt = ival_m1;
        s.convert = tick && gate_on;

        // sample counter 1; pretrigger loads on the trigger itself
        sc_enable = r.ctrl.controlled_mode && ((mode != TRIG_PRE) || r.trig_seen);
        if (mode == TRIG_PRE && trig_take && r.ctrl.controlled_mode)
        begin
            s.sample_cnt = r.count_prog;
            s.sc         = (r.count_prog == '0) ? SC_DONE : SC_COUNTING;
        end
        else if (s.convert && sc_enable)
        begin
            case (r.sc)
                SC_IDLE:
                    s.sc = SC_PRIMED;
                SC_PRIMED:
                begin
                    s.sample_cnt = r.count_prog;
                    s.sc         = (r.count_prog == '0) ? SC_DONE : SC_COUNTING;
                end
                SC_COUNTING:
                begin
                    s.sample_cnt = r.sample_cnt - CW'(1);
                    if (r.sample_cnt == CW'(1))
                        s.sc = SC_DONE;
                end
                SC_DONE:
                    s.sc = SC_DONE;
                default:
                    s.sc = SC_IDLE;
            endcase
        end

        // aux counter 2, square output toggles at each zero
        if (r.ctrl.aux_enable)
        begin
            if (r.aux_cnt == '0)
            begin
                s.aux_cnt = r.aux_reload;
                s.aux_out = ~r.aux_out;
                aux_rise  = ~r.aux_out;
            end
            else
                s.aux_cnt = r.aux_cnt - CW'(1);
        end
        else
        begin
            s.aux_cnt = r.aux_reload;
            s.aux_out = 1'b0;
        end

        // status word as software sees it
        stat = '{running: gate_on, acq_done: (r.sc == SC_DONE), conv_armed: r.conv_armed,
                 trig_seen: r.trig_seen, count_irq_flag: r.count_irq_flag};

        // bus: ack one edge after the request, writes land at the ack edge
        wr_go    = req.cyc && req.stb && req.we && r.ack;
        setup_go = wr_go && (req.adr == ADR_SETUP);
        irq_clr  = wr_go && (req.adr == ADR_IRQ_CLEAR);
        if (req.cyc && req.stb && !r.ack)
        begin
            s.ack = 1'b1;
            case (req.adr)
                ADR_CTRL:     s.rdata = {{(32-CTRL_W){1'b0}}, r.ctrl};
                ADR_INTERVAL: s.rdata = {{(32-CW){1'b0}}, r.interval};
                ADR_COUNT:    s.rdata = {{(32-CW){1'b0}}, r.count_prog};
                ADR_STATUS:   s.rdata = {r.sample_cnt, {STAT_PAD_W{1'b0}}, stat};
                ADR_DAC0:     s.rdata = {{(32-DW){1'b0}}, r.dac0_data};
                ADR_DAC1:     s.rdata = {{(32-DW){1'b0}}, r.dac1_data};
                ADR_AUX:      s.rdata = {{(32-CW){1'b0}}, r.aux_reload};
                default:      s.rdata = 32'h0000_0000;
            endcase
        end
        if (wr_go)
        begin
            case (req.adr)
                ADR_CTRL:
                begin
                    wmerged = lane_merge({{(32-CTRL_W){1'b0}}, r.ctrl}, req.dat, req.sel);
                    s.ctrl  = wmerged[CTRL_W-1:0];
                end
                ADR_INTERVAL:
                begin
                    wmerged    = lane_merge({{(32-CW){1'b0}}, r.interval}, req.dat, req.sel);
                    s.interval = wmerged[CW-1:0];
                end
                ADR_COUNT:
                begin
                    wmerged      = lane_merge({{(32-CW){1'b0}}, r.count_prog}, req.dat, req.sel);
                    s.count_prog = wmerged[CW-1:0];
                end
                ADR_DAC0:
                begin
                    wmerged     = lane_merge({{(32-DW){1'b0}}, r.dac0_data}, req.dat, req.sel);
                    s.dac0_data = wmerged[DW-1:0];
                end
                ADR_DAC1:
                begin
                    wmerged     = lane_merge({{(32-DW){1'b0}}, r.dac1_data}, req.dat, req.sel);
                    s.dac1_data = wmerged[DW-1:0];
                end
                ADR_AUX:
                begin
                    wmerged      = lane_merge({{(32-CW){1'b0}}, r.aux_reload}, req.dat, req.sel);
                    s.aux_reload = wmerged[CW-1:0];
                end
                default:
                    wmerged = 32'h0000_0000;
            endcase
        end

        // a new setup rearms trigger, convert and sample counter
        if (setup_go)
        begin
            s.trig_seen    = 1'b0;
            s.conv_armed   = 1'b0;
            s.sc           = SC_IDLE;
            s.sample_cnt   = '0;
            s.interval_cnt = ival_m1;
        end

        // dac outputs: level-sensitive when selected, direct otherwise
        if (!s.ctrl.dac0_load_select || !upd_level)
            s.dac0_q = s.dac0_data;
        if (!s.ctrl.dac1_load_select || !upd_level)
            s.dac1_q = s.dac1_data;

        // sticky flag; a set in the clearing cycle wins
        s.count_irq_flag = (r.count_irq_flag && !irq_clr) || upd_rise || aux_rise;
        s.irq            = s.count_irq_flag && s.ctrl.count_irq_enable;
    end

    // single register stage, frozen while ce is low
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            r                <= '0;
            r.ctrl           <= CTRL_RST;
            r.interval       <= INTERVAL_RST;
            r.count_prog     <= COUNT_RST;
            r.aux_reload     <= AUX_RST;
            r.dac0_data      <= DAC_RST;
            r.dac1_data      <= DAC_RST;
            r.dac0_q         <= DAC_RST;
            r.dac1_q         <= DAC_RST;
            r.sc             <= SC_IDLE;
        end
        else if (ce)
            r <= s;
    end

    // outputs straight from state flops
    assign wb_dat_o    = r.rdata;
    assign wb_ack_o    = r.ack;
    assign adc_convert = r.convert;
    assign dac0_out    = r.dac0_q;
    assign dac1_out    = r.dac1_q;
    assign count_irq   = r.irq;

endmodule : dts_sequencer

/* File: hdl/dts_pkg.sv */
// shared constants and types of the acquisition trigger sequencer
package dts_pkg;

    // wishbone register map, byte addresses of aligned words
    localparam int unsigned ADR_W          = 8;
    localparam logic [7:0]  ADR_CTRL       = 8'h00;
    localparam logic [7:0]  ADR_INTERVAL   = 8'h04;
    localparam logic [7:0]  ADR_COUNT      = 8'h08;
    localparam logic [7:0]  ADR_STATUS     = 8'h0c;
    localparam logic [7:0]  ADR_IRQ_CLEAR  = 8'h10;
    localparam logic [7:0]  ADR_DAC0       = 8'h14;
    localparam logic [7:0]  ADR_DAC1       = 8'h18;
    localparam logic [7:0]  ADR_AUX        = 8'h1c;
    localparam logic [7:0]  ADR_SETUP      = 8'h20;

    // widths and reset values
    localparam int unsigned CNT_W          = 16;
    localparam int unsigned DAC_W          = 12;
    localparam int unsigned CTRL_W         = 9;
    localparam int unsigned STAT_FLAGS_W   = 5;
    localparam int unsigned STAT_PAD_W     = 32 - CNT_W - STAT_FLAGS_W;
    localparam logic [15:0] INTERVAL_RST   = 16'h0001;
    localparam logic [15:0] COUNT_RST      = 16'h0000;
    localparam logic [15:0] AUX_RST        = 16'h0000;
    localparam logic [11:0] DAC_RST        = 12'h000;
    localparam logic [8:0]  CTRL_RST       = 9'h000;

    // control word, bit 0 is acq_enable, bit 8 is aux_enable
    typedef struct packed {
        logic aux_enable;
        logic count_irq_enable;
        logic dac1_load_select;
        logic dac0_load_select;
        logic controlled_mode;
        logic select_a;
        logic posttrig_select;
        logic ext_conv_enable;
        logic acq_enable;
    } dts_ctrl_t;

    // status flags, bit 0 is count_irq_flag
    typedef struct packed {
        logic running;
        logic acq_done;
        logic conv_armed;
        logic trig_seen;
        logic count_irq_flag;
    } dts_stat_t;

    // wishbone request as seen by the slave
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } dts_wb_req_t;

    typedef enum {TRIG_NONE, TRIG_POST, TRIG_PRE} dts_trig_mode_t;
    typedef enum {SC_IDLE, SC_PRIMED, SC_COUNTING, SC_DONE} dts_sc_state_t;

endpackage : dts_pkg

/* File: hdl/dts_edge_sync.sv */
// two-flop synchroniser with edge detection for one external pin
`timescale 1ns/1ns
module dts_edge_sync
    import dts_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
)
(
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    input  wire logic din,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } dts_sync_st_t;

    dts_sync_st_t r;
    dts_sync_st_t s;

    // meta feeds only sync; edges compare sync with prev
    always_comb
    begin
        s      = r;
        s.meta = din;
        s.sync = r.meta;
        s.prev = r.sync;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            r <= {RST_VAL, RST_VAL, RST_VAL};
        else if (ce)
            r <= s;
    end

    assign level = r.sync;
    assign rise  = r.sync & ~r.prev;
    assign fall  = ~r.sync & r.prev;

endmodule : dts_edge_sync

/* File: test/dts_sequencer_asserts.sv */
// port-level assertion checker for the acquisition trigger sequencer
`timescale 1ns/1ns
module dts_sequencer_chk
    import dts_pkg::*;
#(
    parameter int unsigned CW = CNT_W,
    parameter int unsigned DW = DAC_W
)
(
    input wire logic          clk,
    input wire logic          resetn,
    input wire logic          ce,
    input wire logic          wb_cyc_i,
    input wire logic          wb_stb_i,
    input wire logic          wb_we_i,
    input wire logic [7:0]    wb_adr_i,
    input wire logic [3:0]    wb_sel_i,
    input wire logic [31:0]   wb_dat_i,
    input wire logic [31:0]   wb_dat_o,
    input wire logic          wb_ack_o,
    input wire logic          ext_convert_n,
    input wire logic          ext_acq_trigger,
    input wire logic          ext_dac_update_n,
    input wire logic          adc_convert,
    input wire logic [DW-1:0] dac0_out,
    input wire logic [DW-1:0] dac1_out,
    input wire logic          count_irq
);
    logic [8:0]    ctl_r;
    logic [DW-1:0] dac0_r;
    logic [3:0]    low_r;
    logic [3:0]    fall_r;
    logic          cprev_r;
    logic          wr_ack;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    assign wr_ack = wb_ack_o && wb_we_i && ce;
    // shadow of bus writes and pin ages; writes land at the ack edge as in the design
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctl_r   <= CTRL_RST;
            dac0_r  <= '0;
            low_r   <= 4'h0;
            fall_r  <= 4'hf;
            cprev_r <= 1'b1;
        end
        else
        begin
            if (wr_ack && wb_adr_i == ADR_CTRL)
                ctl_r <= {wb_sel_i[1] ? wb_dat_i[8] : ctl_r[8], wb_sel_i[0] ? wb_dat_i[7:0] : ctl_r[7:0]};
            if (wr_ack && wb_adr_i == ADR_DAC0)
                dac0_r <= wb_dat_i[DW-1:0];
            low_r   <= ext_dac_update_n ? 4'h0 : (low_r == 4'hf ? low_r : low_r + 4'h1);
            fall_r  <= (cprev_r && !ext_convert_n) ? 4'h0 : (fall_r == 4'hf ? fall_r : fall_r + 4'h1);
            cprev_r <= ext_convert_n;
        end
    end

    property p_ack_pulse;
        wb_ack_o && ce |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_resp;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("ack missing after request");
    property p_conv_single;
        ctl_r[1] && adc_convert |=> !adc_convert;
    endproperty
    a_conv_single: assert property (p_conv_single) else $error("convert pulse too long");
    property p_conv_cause;
        ctl_r[1] && adc_convert |-> fall_r <= 4'h6;
    endproperty
    a_conv_cause: assert property (p_conv_cause) else $error("convert without pin fall");
    property p_upd_irq;
        ctl_r[7] && $rose(ext_dac_update_n) |-> ##[1:6] count_irq;
    endproperty
    a_upd_irq: assert property (p_upd_irq) else $error("update rise gave no irq");
    property p_clear;
        wr_ack && wb_adr_i == ADR_IRQ_CLEAR && low_r == 4'h0 && !ctl_r[8] |-> ##[1:2] !count_irq;
    endproperty
    a_clear: assert property (p_clear) else $error("irq not cleared");
    property p_dac_hold;
        ctl_r[5] && $changed(dac0_out) |-> low_r != 4'h0 || $past(low_r) != 4'h0 || $past(low_r, 2) != 4'h0;
    endproperty
    a_dac_hold: assert property (p_dac_hold) else $error("dac0 moved while update high");
    property p_dac_now;
        wr_ack && wb_adr_i == ADR_DAC0 && ctl_r[5] && low_r >= 4'h4 |-> ##[1:3] dac0_out == dac0_r;
    endproperty
    a_dac_now: assert property (p_dac_now) else $error("dac0 write not immediate");
endmodule : dts_sequencer_chk

bind dts_sequencer dts_sequencer_chk #(.CW(CW), .DW(DW)) i_chk
(
    .clk(clk), .resetn(resetn), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_convert_n(ext_convert_n),
    .ext_acq_trigger(ext_acq_trigger), .ext_dac_update_n(ext_dac_update_n),
    .adc_convert(adc_convert), .dac0_out(dac0_out), .dac1_out(dac1_out), .count_irq(count_irq)
);

/* File: test/dts_pins_model.sv */
// behavioural model of the external timing sources on the three pins
`timescale 1ns/1ns
module dts_pins_model
(
    input  wire logic clk,
    output logic      conv_n,
    output logic      trig,
    output logic      upd_n
);
    localparam int HOLD = 4; // every level held 4 clocks, above the 3-cycle minimum

    // idle levels from time zero
    initial
    begin
        conv_n = 1'b1;
        trig   = 1'b0;
        upd_n  = 1'b1;
    end

    task automatic conv_level(input logic v);
        @(posedge clk);
        conv_n <= v;
        repeat (HOLD) @(posedge clk);
    endtask : conv_level

    task automatic conv_pulses(input int n);
        repeat (n)
        begin
            conv_level(1'b0);
            conv_level(1'b1);
        end
    endtask : conv_pulses

    task automatic trig_rise();
        @(posedge clk);
        trig <= 1'b1;
        repeat (HOLD) @(posedge clk);
        trig <= 1'b0;
        repeat (HOLD) @(posedge clk);
    endtask : trig_rise

    task automatic upd_level(input logic v);
        @(posedge clk);
        upd_n <= v;
        repeat (HOLD) @(posedge clk);
    endtask : upd_level
endmodule : dts_pins_model

/* File: test/tb_top.sv */
// self-checking bench: bus tasks, pin model and sequenced checks
`timescale 1ns/1ns
module tb_top
    import dts_pkg::*;
();
    logic             clk = 1'b0;
    logic             resetn = 1'b0;
    logic             cyc = 1'b0;
    logic             stb = 1'b0;
    logic             we = 1'b0;
    logic [7:0]       adr = 8'h00;
    logic [31:0]      wdat = 32'h0;
    logic             ce = 1'b1;
    logic [3:0]       sel = 4'hf;
    logic [31:0]      rdat;
    logic [31:0]      rd;
    logic             ack;
    logic             conv_n;
    logic             trig;
    logic             upd_n;
    logic             adc_cv;
    logic             irq;
    logic [DAC_W-1:0] dac0;
    logic [DAC_W-1:0] dac1;
    int               bad_count = 0;
    int               total_checks = 0;
    int               n_conv = 0;
    int               base = 0;

    always #4 clk = ~clk;
    // conversions seen by the converter
    always @(posedge clk) if (adc_cv === 1'b1) n_conv <= n_conv + 1;

    dts_pins_model i_pins (.clk(clk), .conv_n(conv_n), .trig(trig), .upd_n(upd_n));

    dts_sequencer i_dut
    (
        .clk(clk), .resetn(resetn), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ext_convert_n(conv_n), .ext_acq_trigger(trig), .ext_dac_update_n(upd_n),
        .adc_convert(adc_cv), .dac0_out(dac0), .dac1_out(dac1), .count_irq(irq)
    );

    task automatic report_and_stop();
        if (bad_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one classic cycle; held until ack is sampled, released at that edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20)
            chk("ack", 32'h1, 32'h0);
    endtask : xfer

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rchk

    task automatic stat(input int b, input logic e);
        xfer(1'b0, ADR_STATUS, 32'h0);
        chk("status bit", {31'h0, e}, {31'h0, rd[b]});
    endtask : stat

    // pins need a few clocks to pass the synchronisers before counting
    task automatic cnt(input int e);
        repeat (10) @(posedge clk);
        chk("conversions", e, n_conv - base);
    endtask : cnt

    task automatic setup(input logic [31:0] c);
        xfer(1'b1, ADR_CTRL, c);
        xfer(1'b1, ADR_SETUP, 32'h0);
        base = n_conv;
    endtask : setup

    initial
    begin
        repeat (40000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end

    initial
    begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rchk(ADR_CTRL, 32'h0, "ctrl");
        rchk(ADR_INTERVAL, 32'h1, "interval");
        rchk(ADR_STATUS, 32'h0, "status");
        xfer(1'b1, 8'h30, 32'hffff);
        rchk(8'h30, 32'h0, "unmapped");
        // posttrigger, convert high at trigger, count 3
        xfer(1'b1, ADR_COUNT, 32'h3);
        setup(32'h017);
        i_pins.conv_pulses(2);
        cnt(0);
        i_pins.trig_rise();
        i_pins.conv_pulses(3);
        cnt(2);
        i_pins.trig_rise();
        i_pins.conv_pulses(6);
        cnt(5);
        stat(1, 1'b1);
        // posttrigger, convert low at trigger
        setup(32'h017);
        i_pins.conv_level(1'b0);
        i_pins.trig_rise();
        i_pins.conv_level(1'b1);
        i_pins.conv_level(1'b0);
        cnt(1);
        i_pins.conv_level(1'b1);
        i_pins.conv_pulses(6);
        cnt(5);
        // free-run start by trigger, no limit
        setup(32'h007);
        i_pins.trig_rise();
        i_pins.conv_pulses(7);
        cnt(6);
        // no mode bit: trigger ignored
        setup(32'h003);
        i_pins.trig_rise();
        i_pins.conv_pulses(2);
        cnt(2);
        stat(1, 1'b0);
        // pretrigger with controlled mode, two samples after trigger
        xfer(1'b1, ADR_COUNT, 32'h2);
        setup(32'h01b);
        i_pins.conv_pulses(3);
        cnt(3);
        i_pins.trig_rise();
        i_pins.conv_pulses(4);
        cnt(5);
        // internal pacing, posttrigger, count 3; interval written through one byte lane
        sel <= 4'h1;
        xfer(1'b1, ADR_INTERVAL, 32'hffff_ff08);
        sel <= 4'hf;
        rchk(ADR_INTERVAL, 32'h8, "interval lane");
        xfer(1'b1, ADR_COUNT, 32'h3);
        setup(32'h015);
        repeat (30) @(posedge clk);
        cnt(0);
        i_pins.trig_rise();
        repeat (50) @(posedge clk);
        cnt(5);
        stat(3, 1'b1);
        // dac update level and counter interrupt
        setup(32'h0a0);
        xfer(1'b1, ADR_DAC0, 32'habc);
        repeat (4) @(posedge clk);
        chk("dac0", 32'h0, {20'h0, dac0});
        i_pins.upd_level(1'b0);
        chk("dac0", 32'habc, {20'h0, dac0});
        xfer(1'b1, ADR_DAC0, 32'h123);
        repeat (3) @(posedge clk);
        chk("dac0", 32'h123, {20'h0, dac0});
        xfer(1'b1, ADR_DAC1, 32'h456);
        repeat (3) @(posedge clk);
        chk("dac1", 32'h456, {20'h0, dac1});
        i_pins.upd_level(1'b1);
        chk("irq", 32'h1, {31'h0, irq});
        stat(0, 1'b1);
        xfer(1'b1, ADR_IRQ_CLEAR, 32'h0);
        stat(0, 1'b0);
        setup(32'h020);
        i_pins.upd_level(1'b0);
        i_pins.upd_level(1'b1);
        stat(0, 1'b1);
        chk("irq", 32'h0, {31'h0, irq});
        // auxiliary counter sets the same flag
        xfer(1'b1, ADR_IRQ_CLEAR, 32'h0);
        xfer(1'b1, ADR_AUX, 32'h3);
        setup(32'h180);
        // freeze just before the aux counter wraps; nothing may move while ce is low
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        chk("irq frozen", 32'h0, {31'h0, irq});
        ce <= 1'b1;
        repeat (3) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        stat(0, 1'b1);
        report_and_stop();
    end
endmodule : tb_top
